/* dvp_pkg.sv */
// constants, register layout and state types of the attenuator control block
package dvp_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int ZC_WINDOW_MS = 50;
  localparam int NV_PROGRAM_MS = 10;
  localparam int ZC_WINDOW_CYCLES = ZC_WINDOW_MS * (CLK_HZ / 1000);
  localparam int NV_PROGRAM_CYCLES = NV_PROGRAM_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 23;

  // address byte: fixed upper nibble, then three pin levels, then r/w
  localparam logic [3:0] ADDR_FIXED = 4'h5;

  // command byte select codes in bits 7..6
  localparam logic [1:0] SEL_WIPER0 = 2'h0;
  localparam logic [1:0] SEL_WIPER1 = 2'h1;
  localparam logic [1:0] SEL_SETUP = 2'h2;
  localparam logic [1:0] SEL_RESERVED = 2'h3;

  // attenuator_setup fields, only the low three bits are kept
  localparam int SETUP_VOLATILE_BIT = 2;
  localparam int SETUP_ZC_BIT = 1;
  localparam int SETUP_TABLE_BIT = 0;
  localparam logic [7:0] SETUP_RESET = 8'h87;

  // wiper_position reset: mute of the table selected by SETUP_RESET
  localparam logic [5:0] WIPER_RESET = 6'h21;

  // step tables
  localparam logic [5:0] MUTE_64 = 6'h3f;
  localparam logic [5:0] MUTE_34 = 6'h21;
  localparam logic [5:0] T34_END_1DB = 6'h0c;
  localparam logic [5:0] T34_END_2DB = 6'h18;
  localparam logic [6:0] T34_BASE_2DB = 7'h0c;
  localparam logic [6:0] T34_BASE_3DB = 7'h24;
  localparam logic [6:0] MUTE_DB = 7'h5a;

  // read order and wrap
  localparam logic [1:0] RD_WIPER0 = 2'h0;
  localparam logic [1:0] RD_WIPER1 = 2'h1;
  localparam logic [1:0] RD_SETUP = 2'h2;

  typedef enum logic [2:0] {
    DVP_IDLE = 3'b000,
    DVP_ADDR = 3'b001,
    DVP_ADDR_ACK = 3'b010,
    DVP_CMD = 3'b011,
    DVP_CMD_ACK = 3'b100,
    DVP_TX = 3'b101,
    DVP_TX_ACK = 3'b110,
    DVP_IGNORE = 3'b111
  } dvp_state_t;
endpackage

/* dvp_ctrl.sv */
// serial slave control of the dual-channel attenuator
// How it works
// RULE1: acked wiper command opens 50 ms window
// RULE2: each channel applies at own zero crossing
// RULE3: no crossing, apply when window ends
// RULE4: gating off, apply right after acknowledge
// RULE5: 64-step table: dB equals position, 63 mute
// RULE6: 34-step table: 1, 2, 3 dB steps, 33 mute
// RULE7: command top bits select wiper0, wiper1, setup
// RULE8: code 11 reserved, no action taken
// RULE9: low six bits become selected wiper position
// RULE10: setup bits 5..3 ignored
// RULE11: setup bit 2 picks volatile or nonvolatile
// RULE12: volatile mode: wipers start at mute
// RULE13: setup bit 1 enables zero-crossing gating
// RULE14: setup bit 0 picks step table, both channels
// RULE15: bus ignored while enable input high
// RULE16: address is 0101, pins, then r/w
// RULE17: accept only when pins match address bits
// RULE18: byte after write address is command
// RULE19: read address acked, then data sent
// RULE20: read order wiper0, wiper1, setup
// RULE21: master acks wanted bytes, nacks last
// RULE22: acked setup byte wraps to wiper0
// RULE23: nonvolatile write programs at stop
// RULE24: no address ack while programming
// RULE25: with gating, programming waits for window
// RULE26: many command bytes per write handled
// RULE27: out-of-range wiper value means mute
`timescale 1ns/1ns
module dvp_ctrl #(
  parameter int ZC_WINDOW_CYCLES = dvp_pkg::ZC_WINDOW_CYCLES,
  parameter int NV_PROGRAM_CYCLES = dvp_pkg::NV_PROGRAM_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic comm_enable_n,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic chan0_terminals_equal,
  input wire logic chan1_terminals_equal,
  output logic [5:0] wiper0_pos,
  output logic [5:0] wiper1_pos,
  output logic [6:0] wiper0_atten_db,
  output logic [6:0] wiper1_atten_db,
  output logic table34_sel,
  output logic zc_enabled,
  output logic storage_persistence_sel,
  output logic nv_busy
);
  localparam logic [dvp_pkg::CNT_W-1:0] WIN_LAST =
    dvp_pkg::CNT_W'(ZC_WINDOW_CYCLES - 1);
  localparam logic [dvp_pkg::CNT_W-1:0] NV_LAST =
    dvp_pkg::CNT_W'(NV_PROGRAM_CYCLES - 1);

  // attenuation in dB of a position under the selected table
  function automatic logic [6:0] atten_db(input logic [5:0] pos,
                                          input logic t34);
    logic [6:0] p;
    p = {1'b0, pos};
    atten_db = dvp_pkg::MUTE_DB;
    if (!t34) begin
      if (pos != dvp_pkg::MUTE_64) begin // RULE5
        atten_db = p;
      end
    end else if (pos <= dvp_pkg::T34_END_1DB) begin // RULE6
      atten_db = p;
    end else if (pos <= dvp_pkg::T34_END_2DB) begin // RULE6
      atten_db = 7'(dvp_pkg::T34_BASE_2DB +
                    ((p - {1'b0, dvp_pkg::T34_END_1DB}) << 1));
    end else if (pos < dvp_pkg::MUTE_34) begin // RULE6
      atten_db = 7'(dvp_pkg::T34_BASE_3DB +
                    (p - {1'b0, dvp_pkg::T34_END_2DB}) * 7'h03);
    end else begin
      atten_db = dvp_pkg::MUTE_DB; // RULE27
    end
  endfunction

  // byte returned for a read slot
  function automatic logic [7:0] rd_byte(input logic [1:0] idx,
                                         input logic [5:0] w0,
                                         input logic [5:0] w1,
                                         input logic [2:0] cfg);
    if (idx == dvp_pkg::RD_WIPER0) begin
      rd_byte = {dvp_pkg::SEL_WIPER0, w0};
    end else if (idx == dvp_pkg::RD_WIPER1) begin
      rd_byte = {dvp_pkg::SEL_WIPER1, w1};
    end else begin
      rd_byte = {dvp_pkg::SEL_SETUP, 3'h0, cfg};
    end
  endfunction

  // link side: each scl rise samples sda and toggles a flag
  typedef struct packed {
    logic bit_val;
    logic tog;
  } dvp_link_t;

  dvp_link_t lnk;
  dvp_link_t next_lnk;

  always_comb begin
    next_lnk = lnk;
    next_lnk.bit_val = sda_in;
    next_lnk.tog = ~lnk.tog;
  end

  always_ff @(posedge scl or negedge reset_n) begin
    if (!reset_n) begin
      lnk <= '0;
    end else begin
      lnk <= next_lnk;
    end
  end

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] tog_s;
    logic [1:0] ce_n_s;
    logic [1:0][1:0] zc_s;
    logic [1:0][2:0] pins_s;
    dvp_pkg::dvp_state_t state;
    logic [2:0] bitcnt;
    logic byte_done;
    logic [7:0] shreg;
    logic [7:0] txbyte;
    logic [1:0] rd_idx;
    logic rw;
    logic mack;
    logic oe;
    logic [2:0] cfg;
    logic [1:0][5:0] pend;
    logic [1:0][5:0] wip;
    logic [1:0][6:0] att;
    logic [1:0] wait_zc;
    logic [1:0][dvp_pkg::CNT_W-1:0] win;
    logic dirty;
    logic nv_defer;
    logic busy;
    logic [dvp_pkg::CNT_W-1:0] nv_cnt;
  } dvp_state_reg_t;

  dvp_state_reg_t s;
  dvp_state_reg_t next_s;

  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic [1:0] sel;

  always_comb begin
    next_s = s;
    rise = s.tog_s[1] ^ s.tog_s[2];
    fall = s.scl_s[2] & ~s.scl_s[1];
    start_ev = s.scl_s[1] & s.scl_s[2] & s.sda_s[2] & ~s.sda_s[1];
    stop_ev = s.scl_s[1] & s.scl_s[2] & ~s.sda_s[2] & s.sda_s[1];
    sel = s.shreg[7:6];

    // two-stage synchronisers, third stage only for edge detection
    next_s.scl_s = {s.scl_s[1:0], scl};
    next_s.sda_s = {s.sda_s[1:0], sda_in};
    next_s.tog_s = {s.tog_s[1:0], lnk.tog};
    next_s.ce_n_s = {s.ce_n_s[0], comm_enable_n};
    next_s.zc_s[0] = {s.zc_s[0][0], chan0_terminals_equal};
    next_s.zc_s[1] = {s.zc_s[1][0], chan1_terminals_equal};
    next_s.pins_s[0] = {addr_select_bit2, addr_select_bit1,
                        addr_select_bit0};
    next_s.pins_s[1] = s.pins_s[0];

    // per-channel window, applies at crossing or at expiry
    for (int ch = 0; ch < 2; ch++) begin
      if (s.wait_zc[ch]) begin
        if (s.zc_s[ch][1]) begin // RULE2
          next_s.wip[ch] = s.pend[ch];
          next_s.wait_zc[ch] = 1'b0;
        end else if (s.win[ch] == WIN_LAST) begin // RULE3
          next_s.wip[ch] = s.pend[ch];
          next_s.wait_zc[ch] = 1'b0;
        end else begin
          next_s.win[ch] = s.win[ch] + 1'b1; // RULE1
        end
      end
    end

    // programming cycle timer
    if (s.busy) begin
      if (s.nv_cnt == NV_LAST) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.nv_cnt = s.nv_cnt + 1'b1;
      end
    end else if (s.nv_defer && s.wait_zc == 2'b00) begin // RULE25
      next_s.nv_defer = 1'b0;
      next_s.busy = 1'b1;
      next_s.nv_cnt = '0;
    end

    if (s.ce_n_s[1]) begin // RULE15
      next_s.state = dvp_pkg::DVP_IDLE;
      next_s.oe = 1'b0;
      next_s.byte_done = 1'b0;
    end else if (start_ev) begin
      next_s.state = dvp_pkg::DVP_ADDR;
      next_s.bitcnt = 3'h0;
      next_s.byte_done = 1'b0;
      next_s.oe = 1'b0;
    end else if (stop_ev) begin
      next_s.state = dvp_pkg::DVP_IDLE;
      next_s.oe = 1'b0;
      next_s.byte_done = 1'b0;
      if (s.dirty) begin // RULE23
        next_s.dirty = 1'b0;
        if (s.cfg[dvp_pkg::SETUP_ZC_BIT] && s.wait_zc != 2'b00) begin
          next_s.nv_defer = 1'b1; // RULE25
        end else begin
          next_s.busy = 1'b1;
          next_s.nv_cnt = '0;
        end
      end
    end else begin
      case (s.state)
        dvp_pkg::DVP_ADDR, dvp_pkg::DVP_CMD: begin
          if (rise) begin
            next_s.shreg = {s.shreg[6:0], lnk.bit_val};
            next_s.bitcnt = s.bitcnt + 1'b1;
            if (s.bitcnt == 3'h7) begin
              next_s.byte_done = 1'b1;
            end
          end
          if (fall && s.byte_done) begin
            next_s.byte_done = 1'b0;
            if (s.state == dvp_pkg::DVP_CMD) begin
              next_s.oe = 1'b1; // RULE18
              next_s.state = dvp_pkg::DVP_CMD_ACK;
            end else if (s.shreg[7:1] ==
                         {dvp_pkg::ADDR_FIXED, s.pins_s[1]} // RULE16
                         && !s.busy && !s.nv_defer) begin // RULE17 RULE24
              next_s.oe = 1'b1;
              next_s.rw = s.shreg[0];
              next_s.state = dvp_pkg::DVP_ADDR_ACK;
            end else begin
              next_s.state = dvp_pkg::DVP_IGNORE;
            end
          end
        end
        dvp_pkg::DVP_ADDR_ACK: begin
          if (fall) begin
            next_s.bitcnt = 3'h0;
            if (s.rw) begin // RULE19
              next_s.txbyte = rd_byte(dvp_pkg::RD_WIPER0, s.pend[0],
                                      s.pend[1], s.cfg); // RULE20
              next_s.rd_idx = dvp_pkg::RD_WIPER1;
              next_s.oe = ~next_s.txbyte[7];
              next_s.state = dvp_pkg::DVP_TX;
            end else begin
              next_s.oe = 1'b0;
              next_s.state = dvp_pkg::DVP_CMD; // RULE18
            end
          end
        end
        dvp_pkg::DVP_CMD_ACK: begin
          if (fall) begin
            next_s.oe = 1'b0;
            next_s.bitcnt = 3'h0;
            next_s.state = dvp_pkg::DVP_CMD; // RULE26
            if (sel == dvp_pkg::SEL_WIPER0 ||
                sel == dvp_pkg::SEL_WIPER1) begin // RULE7
              next_s.pend[sel[0]] = s.shreg[5:0]; // RULE9
              if (s.cfg[dvp_pkg::SETUP_ZC_BIT]) begin // RULE13
                next_s.wait_zc[sel[0]] = 1'b1; // RULE1
                next_s.win[sel[0]] = '0;
              end else begin
                next_s.wip[sel[0]] = s.shreg[5:0]; // RULE4
                next_s.wait_zc[sel[0]] = 1'b0;
              end
              if (!s.cfg[dvp_pkg::SETUP_VOLATILE_BIT]) begin // RULE11
                next_s.dirty = 1'b1;
              end
            end else if (sel == dvp_pkg::SEL_SETUP) begin // RULE7
              next_s.cfg = s.shreg[2:0]; // RULE10
              if (!s.shreg[dvp_pkg::SETUP_VOLATILE_BIT]) begin // RULE11
                next_s.dirty = 1'b1;
              end
            end else if (sel == dvp_pkg::SEL_RESERVED) begin
              next_s.state = dvp_pkg::DVP_CMD; // RULE8
            end
          end
        end
        dvp_pkg::DVP_TX: begin
          if (rise) begin
            next_s.bitcnt = s.bitcnt + 1'b1;
            if (s.bitcnt == 3'h7) begin
              next_s.byte_done = 1'b1;
            end
          end
          if (fall) begin
            if (s.byte_done) begin
              next_s.byte_done = 1'b0;
              next_s.oe = 1'b0;
              next_s.mack = 1'b0;
              next_s.state = dvp_pkg::DVP_TX_ACK;
            end else begin
              next_s.txbyte = {s.txbyte[6:0], 1'b0};
              next_s.oe = ~s.txbyte[6];
            end
          end
        end
        dvp_pkg::DVP_TX_ACK: begin
          if (rise) begin
            next_s.mack = ~lnk.bit_val; // RULE21
          end
          if (fall) begin
            if (s.mack) begin
              next_s.txbyte = rd_byte(s.rd_idx, s.pend[0], s.pend[1],
                                      s.cfg); // RULE20
              next_s.oe = ~next_s.txbyte[7];
              next_s.bitcnt = 3'h0;
              next_s.state = dvp_pkg::DVP_TX;
              if (s.rd_idx == dvp_pkg::RD_SETUP) begin
                next_s.rd_idx = dvp_pkg::RD_WIPER0; // RULE22
              end else begin
                next_s.rd_idx = s.rd_idx + 1'b1;
              end
            end else begin
              next_s.state = dvp_pkg::DVP_IGNORE; // RULE21
            end
          end
        end
        default: begin
          next_s.oe = 1'b0;
        end
      endcase
    end

    for (int ch = 0; ch < 2; ch++) begin
      next_s.att[ch] = atten_db(next_s.wip[ch],
                                next_s.cfg[dvp_pkg::SETUP_TABLE_BIT]); // RULE14
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.scl_s <= 3'h7;
      s.sda_s <= 3'h7;
      s.ce_n_s <= 2'h3;
      s.state <= dvp_pkg::DVP_IDLE;
      s.cfg <= dvp_pkg::SETUP_RESET[2:0];
      s.pend <= {2{dvp_pkg::WIPER_RESET}}; // RULE12
      s.wip <= {2{dvp_pkg::WIPER_RESET}}; // RULE12
      s.att <= {2{dvp_pkg::MUTE_DB}};
    end else begin
      s <= next_s;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = s.oe;
  assign wiper0_pos = s.wip[0];
  assign wiper1_pos = s.wip[1];
  assign wiper0_atten_db = s.att[0];
  assign wiper1_atten_db = s.att[1];
  assign table34_sel = s.cfg[dvp_pkg::SETUP_TABLE_BIT];
  assign zc_enabled = s.cfg[dvp_pkg::SETUP_ZC_BIT];
  assign storage_persistence_sel = s.cfg[dvp_pkg::SETUP_VOLATILE_BIT];
  assign nv_busy = s.busy | s.nv_defer;
endmodule

/* dvp_master.sv */
// bus master model driving the serial clock and pulling the data line
`timescale 1ns/1ns
module dvp_master #(
  parameter int HALF = 32
) (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // data moves only while the clock is low, sampled at end of high phase
  task automatic bit_io(input logic b, output logic r);
    wt(HALF / 2);
    sda_pull <= ~b;
    wt(HALF / 2);
    scl <= 1'b1;
    wt(HALF);
    r = sda;
    scl <= 1'b0;
  endtask
  // go 1 gives a start, go 0 a stop that leaves the bus idle
  task automatic frame(input logic go);
    wt(HALF / 2);
    sda_pull <= ~go;
    wt(HALF / 2);
    scl <= 1'b1;
    wt(HALF);
    sda_pull <= go;
    wt(HALF);
    if (go) scl <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ack_in, ack_out);
  endtask
endmodule

/* dvp_ctrl_asserts.sv */
// assertions on the attenuator control block ports
`timescale 1ns/1ns
module dvp_ctrl_asserts #(
  parameter int ZC_WINDOW_CYCLES = 200,
  parameter int NV_PROGRAM_CYCLES = 100
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic comm_enable_n,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic chan0_terminals_equal,
  input wire logic chan1_terminals_equal,
  input wire logic [5:0] wiper0_pos,
  input wire logic [5:0] wiper1_pos,
  input wire logic [6:0] wiper0_atten_db,
  input wire logic [6:0] wiper1_atten_db,
  input wire logic table34_sel,
  input wire logic zc_enabled,
  input wire logic storage_persistence_sel,
  input wire logic nv_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic [31:0] busy_cnt;
  logic [3:0] since_stop;
  logic sda_d;
  sequence stop_cond;
    scl && $rose(sda_in);
  endsequence
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt <= 32'h0;
      since_stop <= 4'hf;
      sda_d <= 1'b1;
    end else begin
      busy_cnt <= nv_busy ? busy_cnt + 32'h1 : 32'h0;
      sda_d <= sda_in;
      if (scl && sda_in && !sda_d) since_stop <= 4'h0;
      else if (since_stop != 4'hf) since_stop <= since_stop + 4'h1;
    end
  end
  function automatic logic [6:0] db(logic [5:0] p, logic t);
    if (!t) return (p == 6'h3f) ? 7'h5a : 7'(p);
    if (p <= 6'h0c) return 7'(p);
    if (p <= 6'h18) return 7'(p) * 7'h2 - 7'h0c;
    if (p <= 6'h20) return 7'(p) * 7'h3 - 7'h24;
    return 7'h5a;
  endfunction
  AST_DB_CH0: assert property (
    $stable(wiper0_pos) && $stable(table34_sel) |->
    wiper0_atten_db == db(wiper0_pos, table34_sel))
    else $error("channel 0 attenuation wrong");
  AST_DB_CH1: assert property (
    $stable(wiper1_pos) && $stable(table34_sel) |->
    wiper1_atten_db == db(wiper1_pos, table34_sel))
    else $error("channel 1 attenuation wrong");
  AST_CE_QUIET: assert property (comm_enable_n [*5] |-> !sda_oe)
    else $error("data driven while disabled");
  AST_CE_HOLD: assert property (
    comm_enable_n [*5] |=>
    $stable({table34_sel, zc_enabled, storage_persistence_sel}))
    else $error("setup changed while disabled");
  AST_RESET_MUTE: assert property ($rose(reset_n) |->
    wiper0_pos == 6'h21 && wiper1_pos == 6'h21)
    else $error("wipers not mute after reset");
  AST_OE_SCL_LOW: assert property (
    !comm_enable_n && $changed(sda_oe) |-> !scl)
    else $error("data changed while clock high");
  AST_VOL_NO_PROG: assert property (
    stop_cond ##0 (storage_persistence_sel && !nv_busy) |=> !nv_busy [*8])
    else $error("programming in volatile mode");
  AST_PROG_AT_STOP: assert property (
    $rose(nv_busy) && !zc_enabled |->
    since_stop >= 4'h1 && since_stop <= 4'ha)
    else $error("programming not started by stop");
  AST_PROG_LEN: assert property (
    $fell(nv_busy) && !zc_enabled |-> busy_cnt == NV_PROGRAM_CYCLES)
    else $error("programming length wrong");
  AST_PROG_DEFER: assert property (
    $fell(nv_busy) |-> busy_cnt >= NV_PROGRAM_CYCLES &&
    busy_cnt <= NV_PROGRAM_CYCLES + ZC_WINDOW_CYCLES + 8)
    else $error("deferred programming length wrong");
endmodule
bind dvp_ctrl dvp_ctrl_asserts #(
  .ZC_WINDOW_CYCLES(ZC_WINDOW_CYCLES),
  .NV_PROGRAM_CYCLES(NV_PROGRAM_CYCLES)
) dvp_ctrl_asserts_i (
  .clk_sys, .reset_n, .scl, .sda_in, .sda_oe, .comm_enable_n,
  .addr_select_bit0, .addr_select_bit1, .addr_select_bit2,
  .chan0_terminals_equal, .chan1_terminals_equal, .wiper0_pos,
  .wiper1_pos, .wiper0_atten_db, .wiper1_atten_db, .table34_sel,
  .zc_enabled, .storage_persistence_sel, .nv_busy
);

/* tb.sv */
// self-checking bench for the attenuator control block
`timescale 1ns/1ns
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic comm_enable_n = 1'b0;
  logic [2:0] pins = 3'h0;
  logic chan0_terminals_equal = 1'b0;
  logic chan1_terminals_equal = 1'b0;
  logic scl, sda_pull, sda, sda_out, sda_oe, table34_sel, zc_enabled;
  logic storage_persistence_sel, nv_busy, a;
  logic [5:0] wiper0_pos, wiper1_pos, w0, w1;
  logic [6:0] wiper0_atten_db, wiper1_atten_db;
  logic [5:0] pend [2] = '{6'h21, 6'h21};
  logic [7:0] cfg_m = 8'h87;
  logic [7:0] rx;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  localparam int NV_CYC = 1500;
  always #5 clk_sys = ~clk_sys;
  assign sda = (sda_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  dvp_master dvp_master_i (.clk_sys, .sda, .scl, .sda_pull);
  dvp_ctrl #(.ZC_WINDOW_CYCLES(2000), .NV_PROGRAM_CYCLES(NV_CYC)) dvp_ctrl_i (
    .clk_sys, .reset_n, .scl, .sda_in(sda), .sda_out, .sda_oe,
    .comm_enable_n, .addr_select_bit0(pins[0]), .addr_select_bit1(pins[1]),
    .addr_select_bit2(pins[2]), .chan0_terminals_equal,
    .chan1_terminals_equal, .wiper0_pos, .wiper1_pos, .wiper0_atten_db,
    .wiper1_atten_db, .table34_sel, .zc_enabled, .storage_persistence_sel,
    .nv_busy);
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic addr(input logic [2:0] ap, input logic rw, input logic ack);
    dvp_master_i.frame(1'b1);
    dvp_master_i.xfer({dvp_pkg::ADDR_FIXED, ap, rw}, 1'b1, rx, a);
    chk({7'h0, a}, {7'h0, ~ack});
  endtask
  task automatic cmd(input logic [7:0] c);
    dvp_master_i.xfer(c, 1'b1, rx, a);
    chk({7'h0, a}, 8'h0);
    case (c[7:6])
      2'h0: pend[0] = c[5:0];
      2'h1: pend[1] = c[5:0];
      2'h2: cfg_m = {5'h10, c[2:0]};
      default: ;
    endcase
  endtask
  task automatic rd(input int cnt);
    logic [7:0] e [3];
    e = '{{2'h0, pend[0]}, {2'h1, pend[1]}, cfg_m};
    addr(pins, 1'b1, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      dvp_master_i.xfer(8'hff, i == cnt - 1, rx, a);
      chk(rx, e[i % 3]);
    end
    dvp_master_i.frame(1'b0);
  endtask
  // attenuation model: 64-step table in 1 dB steps, 34-step table in 1, 2 and 3 dB steps, 90 dB mute
  function automatic int db_m(input int p, input logic t);
    if (!t) return p == 63 ? 90 : p;
    if (p <= 12) return p;
    if (p <= 24) return 12 + 2 * (p - 12);
    if (p <= 32) return 36 + 3 * (p - 24);
    return 90;
  endfunction
  task automatic outs(input logic [5:0] x0, input logic [5:0] x1);
    chk({1'b0, wiper0_atten_db}, 8'(db_m(x0, cfg_m[0])));
    chk({1'b0, wiper1_atten_db}, 8'(db_m(x1, cfg_m[0])));
    chk({2'h0, wiper0_pos}, {2'h0, x0});
    chk({2'h0, wiper1_pos}, {2'h0, x1});
    chk({5'h0, storage_persistence_sel, zc_enabled, table34_sel},
        {5'h0, cfg_m[2:0]});
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    cyc(60000);
    bad_count++;
    stop_test;
  end
  initial begin
    n = $urandom(32'hf945);
    pins <= 3'($urandom);
    cyc(6);
    reset_n <= 1'b1;
    cyc(6);
    outs(6'h21, 6'h21);
    rd(4);
    addr(pins ^ (3'h1 << ($urandom % 3)), 1'b0, 1'b0);
    dvp_master_i.frame(1'b0);
    comm_enable_n <= 1'b1;
    cyc(4);
    addr(pins, 1'b0, 1'b0);
    dvp_master_i.frame(1'b0);
    comm_enable_n <= 1'b0;
    pins <= 3'($urandom);
    cyc(4);
    w0 = 6'($urandom % 33);
    w1 = 6'($urandom % 33);
    addr(pins, 1'b0, 1'b1);
    cmd({2'h0, w0});
    cmd({2'h1, w1});
    dvp_master_i.frame(1'b0);
    outs(6'h21, 6'h21);
    chan1_terminals_equal <= 1'b1;
    cyc(8);
    outs(6'h21, w1);
    chan1_terminals_equal <= 1'b0;
    n = 0;
    while (wiper0_pos !== w0 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk({7'h0, n > 1100 && n < 1500}, 8'h1);
    addr(pins, 1'b0, 1'b1);
    cmd(8'hb8);
    cmd(8'h3f);
    cyc(8);
    outs(6'h3f, w1);
    cmd(8'hc5);
    cyc(8);
    outs(6'h3f, w1);
    cmd(8'h81);
    cyc(8);
    outs(6'h3f, w1);
    dvp_master_i.frame(1'b0);
    cyc(8);
    chk({7'h0, nv_busy}, 8'h1);
    addr(pins, 1'b0, 1'b0);
    dvp_master_i.frame(1'b0);
    n = 0;
    while (nv_busy !== 1'b0 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk({7'h0, n > 0 && n < NV_CYC}, 8'h1);
    addr(pins, 1'b0, 1'b1);
    dvp_master_i.frame(1'b0);
    rd(3);
    addr(pins, 1'b0, 1'b1);
    cmd(8'h82);
    w0 = 6'($urandom % 33);
    cmd({2'h0, w0});
    w1 = 6'(w1 + 6'h1);
    cmd({2'h1, w1});
    dvp_master_i.frame(1'b0);
    chan0_terminals_equal <= 1'b1;
    cyc(8);
    outs(w0, 6'(w1 - 6'h1));
    chan0_terminals_equal <= 1'b0;
    n = 0;
    while (wiper1_pos !== w1 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk({7'h0, nv_busy}, 8'h1);
    n = 0;
    while (nv_busy !== 1'b0 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk({7'h0, nv_busy}, 8'h0);
    outs(w0, w1);
    reset_n <= 1'b0;
    cyc(6);
    reset_n <= 1'b1;
    pend = '{6'h21, 6'h21};
    cfg_m = 8'h87;
    cyc(6);
    outs(6'h21, 6'h21);
    rd(3);
    stop_test;
  end
endmodule
